// ==== include/codec_rate_params.svh ====
// Constants of the sample-rate and filter control block.
// Assumes the 16-bit register port and a 50 MHz reference clock.
`ifndef CODEC_RATE_PARAMS_SVH
`define CODEC_RATE_PARAMS_SVH

// ****************************************
// Register offsets
// ****************************************
`define CR_A_CTRL1 4'h1
`define CR_A_CTRL2 4'h2
`define CR_A_OVS 4'h3
`define CR_A_DIV 4'h4
`define CR_A_STAT 4'h5

// ****************************************
// Field positions and reset values
// ****************************************
`define CR_BIT_DEC_OVF 7
`define CR_BIT_IIR 5
`define CR_BIT_BYPASS 6
`define CR_DIV_RST 16'h3800
`define CR_P_COARSE 3'h7

// ****************************************
// Timing counts
// ****************************************
`define CR_FRAME_BITS 5'd16
`define CR_LAST_PHASE 5'd30
`define CR_MIN_PERIOD 19'h00020
`define CR_DEC_DELAY 5'd17
`define CR_INT_DELAY 5'd18
`define CR_MOD_INC 10'h080
`define CR_MOD_INC_BYP 10'h020
`define CR_FULL 8'h80
`define CR_FULL_BYP 8'h20

`endif

// ==== include/codec_rate_pkg.sv ====
// Types of the sample-rate and filter control block.
// Assumes nothing beyond the parameter header.
package codec_rate_pkg;

  typedef enum logic [1:0] {
    SER_IDLE = 2'b01,
    SER_SHIFT = 2'b10
  } ser_state_t;

  typedef struct packed {
    logic [18:0] cnt_r;
    logic [18:0] period_r;
    logic [18:0] acc_a_r;
    logic [18:0] acc_d_r;
    logic start_r;
    logic adc_tick_r;
    logic dac_tick_r;
  } rate_state_t;

  typedef struct packed {
    logic [31:0][15:0] words_r;
    logic [15:0] rd_data_r;
  } mem_state_t;

  typedef struct packed {
    logic iir_r;
    logic bypass_r;
    logic [1:0] ovs_r;
    logic [6:0] m_r;
    logic [3:0] n_r;
    logic [2:0] p_r;
    logic ovf_r;
    logic [15:0] rdata_r;
    ser_state_t st_r;
    logic [4:0] ph_r;
    logic sclk_r;
    logic frame_sync_r;
    logic dout_r;
    logic [15:0] tx_r;
    logic din_s1_r;
    logic din_s2_r;
    logic [1:0] cap_r;
    logic [15:0] rx_r;
    logic [4:0] rxn_r;
    logic rx_done_r;
    logic [7:0] ones_r;
    logic [4:0] dw_r;
    logic [4:0] iw_r;
    logic int_pend_r;
    logic [15:0] dac_word_r;
  } ctrl_state_t;

endpackage

// ==== logic/codec_rate_ctrl.sv ====
// Sample-rate generation, filter selection and serial transfer control.
// Assumes a same-clock register master; the serial partner is off chip.
//
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "codec_rate_params.svh"
module codec_rate_ctrl
  import codec_rate_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  input wire logic i_din,
  output logic o_sclk,
  output logic o_frame_sync,
  output logic o_dout,
  input wire logic i_mod_bit,
  output logic o_adc_tick,
  output logic o_dac_tick,
  output logic [15:0] o_dac_word,
  output logic o_fine_mode,
  output logic o_iir_sel,
  output logic o_bypass
);

  ctrl_state_t s;
  ctrl_state_t s_nxt;
  logic frame_start;
  logic adc_tick;
  logic dac_tick;
  logic fir_on;
  logic [9:0] ovs_inc;
  logic [15:0] dec_calc;
  logic dec_sat;
  logic [15:0] dec_rd;
  logic [15:0] int_rd;
  logic [15:0] tx_word;
  logic [4:0] ph_next;
  logic mod_one;

  assign fir_on = !s.iir_r && !s.bypass_r;
  assign mod_one = adc_tick && i_mod_bit;

  // ****************************************
  // Rate generator and delay memories
  // ****************************************
  always_comb begin
    unique case (s.ovs_r)
      2'b01: ovs_inc = 10'h100;
      2'b10: ovs_inc = 10'h200;
      default: ovs_inc = `CR_MOD_INC;
    endcase
    if (s.bypass_r) begin
      ovs_inc = {2'b00, ovs_inc[9:2]};
    end
  end

  rate_gen u_rate (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_m({1'b0, s.m_r} + 8'h1),
    .i_n({1'b0, s.n_r} + 5'h1),
    .i_p({1'b0, s.p_r} + 4'h1),
    .i_bypass(s.bypass_r),
    .i_dac_inc(ovs_inc),
    .o_frame_start(frame_start),
    .o_adc_tick(adc_tick),
    .o_dac_tick(dac_tick)
  );

  delay_mem u_dec_mem (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_wr_en(frame_start),
    .i_wr_addr(s.dw_r),
    .i_wr_data(dec_calc),
    .i_rd_en(frame_start),
    .i_rd_addr(s.dw_r - (`CR_DEC_DELAY - 5'd1)),
    .o_rd_data(dec_rd)
  );

  delay_mem u_int_mem (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_wr_en(s.rx_done_r),
    .i_wr_addr(s.iw_r),
    .i_wr_data(s.rx_r),
    .i_rd_en(frame_start),
    .i_rd_addr(s.iw_r - `CR_INT_DELAY),
    .o_rd_data(int_rd)
  );

  // ****************************************
  // Decimation word from modulator count
  // ****************************************
  always_comb begin
    if (s.bypass_r) begin
      dec_sat = s.ones_r >= `CR_FULL_BYP;
      dec_calc = {s.ones_r[4:0] - 5'h10, 11'h000};
    end else begin
      dec_sat = s.ones_r >= `CR_FULL;
      dec_calc = {s.ones_r[6:0] - 7'h40, 9'h000};
    end
    if (dec_sat) begin
      dec_calc = 16'h7fff;
    end
    tx_word = fir_on ? dec_rd : dec_calc;
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_nxt = s;
    ph_next = s.ph_r + 5'h1;
    s_nxt.rx_done_r = 1'b0;
    s_nxt.int_pend_r = 1'b0;
    s_nxt.din_s1_r = i_din;
    s_nxt.din_s2_r = s.din_s1_r;
    s_nxt.cap_r = {s.cap_r[0], 1'b0};
    // Register port
    if (i_wr) begin
      unique case (i_addr)
        `CR_A_CTRL1: s_nxt.iir_r = i_wdata[`CR_BIT_IIR];
        `CR_A_CTRL2: s_nxt.bypass_r = i_wdata[`CR_BIT_BYPASS];
        `CR_A_OVS: s_nxt.ovs_r = i_wdata[1:0];
        `CR_A_DIV: begin
          s_nxt.m_r = i_wdata[6:0];
          s_nxt.n_r = i_wdata[10:7];
          s_nxt.p_r = i_wdata[13:11];
        end
        default: s_nxt.m_r = s.m_r;
      endcase
    end
    s_nxt.rdata_r = 16'h0;
    if (i_rd) begin
      unique case (i_addr)
        `CR_A_CTRL1: begin
          s_nxt.rdata_r[`CR_BIT_DEC_OVF] = s.ovf_r;
          s_nxt.rdata_r[`CR_BIT_IIR] = s.iir_r;
          s_nxt.ovf_r = 1'b0;
        end
        `CR_A_CTRL2: s_nxt.rdata_r[`CR_BIT_BYPASS] = s.bypass_r;
        `CR_A_OVS: s_nxt.rdata_r[1:0] = s.ovs_r;
        `CR_A_DIV: s_nxt.rdata_r = {2'b00, s.p_r, s.n_r, s.m_r};
        `CR_A_STAT: s_nxt.rdata_r[2:0] = {s.bypass_r, s.st_r == SER_SHIFT, o_fine_mode};
        default: s_nxt.rdata_r = 16'h0;
      endcase
    end
    // Modulator count over one frame; overflow set wins over read clear
    s_nxt.ones_r = frame_start ? {7'h0, mod_one} : s.ones_r + {7'h0, mod_one};
    if (frame_start) begin
      if (dec_sat) begin
        s_nxt.ovf_r = 1'b1;
      end
      s_nxt.dw_r = s.dw_r + 5'h1;
      s_nxt.int_pend_r = fir_on;
    end
    // Serial transfer
    unique case (s.st_r)
      SER_IDLE: begin
        if (frame_start) begin
          s_nxt.st_r = SER_SHIFT;
          s_nxt.ph_r = 5'h0;
          s_nxt.frame_sync_r = 1'b0;
          s_nxt.sclk_r = 1'b1;
          s_nxt.dout_r = tx_word[15];
          s_nxt.tx_r = {tx_word[14:0], 1'b0};
        end
      end
      SER_SHIFT: begin
        s_nxt.ph_r = ph_next;
        s_nxt.frame_sync_r = 1'b1;
        if (ph_next[0]) begin
          s_nxt.sclk_r = 1'b0;
          s_nxt.cap_r[0] = 1'b1;
        end else begin
          s_nxt.sclk_r = 1'b1;
          s_nxt.dout_r = s.tx_r[15];
          s_nxt.tx_r = {s.tx_r[14:0], 1'b0};
        end
        if (s.ph_r == `CR_LAST_PHASE) begin
          s_nxt.st_r = SER_IDLE;
        end
      end
    endcase
    // Input bit taken from the synchroniser two cycles after the fall
    if (s.cap_r[1]) begin
      s_nxt.rx_r = {s.rx_r[14:0], s.din_s2_r};
      s_nxt.rxn_r = s.rxn_r + 5'h1;
      if (s.rxn_r == `CR_FRAME_BITS - 5'h1) begin
        s_nxt.rxn_r = 5'h0;
        s_nxt.rx_done_r = 1'b1;
      end
    end
    // Interpolation word, held for the oversampled DAC ticks
    if (s.rx_done_r) begin
      s_nxt.iw_r = s.iw_r + 5'h1;
      if (!fir_on) begin
        s_nxt.dac_word_r = s.rx_r;
      end
    end
    if (s.int_pend_r) begin
      s_nxt.dac_word_r = int_rd;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s <= '0;
      s.st_r <= SER_IDLE;
      s.frame_sync_r <= 1'b1;
      s.p_r <= `CR_P_COARSE;
    end else begin
      s <= s_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign o_rdata = s.rdata_r;
  assign o_sclk = s.sclk_r;
  assign o_frame_sync = s.frame_sync_r;
  assign o_dout = s.dout_r;
  assign o_adc_tick = adc_tick;
  assign o_dac_tick = dac_tick;
  assign o_dac_word = s.dac_word_r;
  assign o_fine_mode = s.p_r != `CR_P_COARSE;
  assign o_iir_sel = s.iir_r;
  assign o_bypass = s.bypass_r;

  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  a_interval_len: assert property (
    $fell(o_frame_sync) |-> ##31 (s.st_r == SER_IDLE && !o_sclk))
    else $error("transfer interval is not 16 shift clocks");
  a_dout_on_rise: assert property (
    $changed(o_dout) |-> $rose(o_sclk))
    else $error("output bit changed away from a rising edge");
  a_din_on_fall: assert property (
    $fell(o_sclk) |-> ##2 (s.rx_r[0] == $past(s.din_s2_r)))
    else $error("input bit not taken from the falling edge");
  a_reset_coarse: assert property (
    $rose(i_resetn) |-> (s.p_r == 3'h7 && !o_fine_mode && s.ovs_r == 2'b00))
    else $error("reset did not leave coarse mode");
  a_div_write: assert property (
    i_wr && i_addr == `CR_A_DIV |=> s.p_r == $past(i_wdata[13:11])
      && s.n_r == $past(i_wdata[10:7]) && s.m_r == $past(i_wdata[6:0]))
    else $error("divider field lost");
  a_sclk_in_frame: assert property (
    $rose(o_sclk) |-> $past(frame_start) || $past(s.st_r == SER_SHIFT))
    else $error("shift clock outside a transfer");
  a_ovf_sticky: assert property (
    frame_start && dec_sat |=> s.ovf_r)
    else $error("decimation overflow not flagged");
  a_fir_path: assert property (
    frame_start && fir_on && s.st_r == SER_IDLE |=> o_dout == $past(dec_rd[15]))
    else $error("FIR word not taken from delay memory");
  a_iir_dac: assert property (
    s.rx_done_r && !fir_on && !s.int_pend_r |=> o_dac_word == $past(s.rx_r))
    else $error("IIR word not passed straight");

  c_transfer: cover property ($fell(o_frame_sync) ##31 !o_sclk);
  c_fine_mode: cover property (o_fine_mode && frame_start);
  c_bypass: cover property (o_bypass && frame_start);
  c_rx_done: cover property (s.rx_done_r && fir_on);

endmodule

// ==== logic/delay_mem.sv ====
// Delay memory of 32 words of 16 bits for the FIR group delays.
// Assumes one write and one read per frame from the control block.
`timescale 1ns/1ps
module delay_mem
  import codec_rate_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_wr_en,
  input wire logic [4:0] i_wr_addr,
  input wire logic [15:0] i_wr_data,
  input wire logic i_rd_en,
  input wire logic [4:0] i_rd_addr,
  output logic [15:0] o_rd_data
);

  mem_state_t s;
  mem_state_t s_nxt;

  always_comb begin
    s_nxt = s;
    if (i_wr_en) begin
      s_nxt.words_r[i_wr_addr] = i_wr_data;
    end
    if (i_rd_en) begin
      s_nxt.rd_data_r = s.words_r[i_rd_addr];
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s <= '0;
    end else begin
      s <= s_nxt;
    end
  end

  assign o_rd_data = s.rd_data_r;

endmodule

// ==== logic/rate_gen.sv ====
// Frame and converter tick generator from the reference clock.
// Assumes divisor values 1..128, 1..16 and 1..8 from the control block.
`timescale 1ns/1ps
`include "codec_rate_params.svh"
module rate_gen
  import codec_rate_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic [7:0] i_m,
  input wire logic [4:0] i_n,
  input wire logic [3:0] i_p,
  input wire logic i_bypass,
  input wire logic [9:0] i_dac_inc,
  output logic o_frame_start,
  output logic o_adc_tick,
  output logic o_dac_tick
);

  rate_state_t s;
  rate_state_t s_nxt;
  logic [18:0] prod;
  logic [18:0] raw;
  logic [18:0] period_new;
  logic [18:0] sum_a;
  logic [18:0] sum_d;
  logic [9:0] adc_inc;
  logic [18:0] per_use;
  logic at_start;

  // ****************************************
  // Frame period and converter ticks
  // ****************************************
  always_comb begin
    prod = 19'(i_m) * 19'(i_n) * 19'(i_p);
    raw = i_bypass ? {prod[16:0], 2'b00} : {prod[14:0], 4'h0};
    period_new = (raw < `CR_MIN_PERIOD) ? `CR_MIN_PERIOD : raw;
    adc_inc = i_bypass ? `CR_MOD_INC_BYP : `CR_MOD_INC;
    at_start = s.cnt_r == 19'h0;
    // Restart on every frame cycle too, so a frame holds exactly inc ticks when inc is not above the period
    per_use = at_start ? period_new : s.period_r;
    sum_a = (at_start ? 19'h0 : s.acc_a_r) + 19'(adc_inc);
    sum_d = (at_start ? 19'h0 : s.acc_d_r) + 19'(i_dac_inc);
    s_nxt = s;
    s_nxt.start_r = at_start;
    // Multiplier model: converter ticks only, never the shift clock
    s_nxt.acc_a_r = (sum_a >= per_use) ? sum_a - per_use : sum_a;
    s_nxt.adc_tick_r = sum_a >= per_use;
    s_nxt.acc_d_r = (sum_d >= per_use) ? sum_d - per_use : sum_d;
    s_nxt.dac_tick_r = sum_d >= per_use;
    if (at_start) begin
      s_nxt.period_r = period_new;
      s_nxt.cnt_r = period_new - 19'h1;
    end else begin
      s_nxt.cnt_r = s.cnt_r - 19'h1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s <= '0;
    end else begin
      s <= s_nxt;
    end
  end

  assign o_frame_start = s.start_r;
  assign o_adc_tick = s.adc_tick_r;
  assign o_dac_tick = s.dac_tick_r;

  // ****************************************
  // Checks
  // ****************************************
  logic [18:0] gap_r;
  logic [18:0] per_h_r;
  logic seen_r;

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      gap_r <= 19'h0;
      per_h_r <= 19'h0;
      seen_r <= 1'b0;
    end else begin
      gap_r <= s.start_r ? 19'h1 : gap_r + 19'h1;
      if (s.start_r) begin
        per_h_r <= s.period_r;
        seen_r <= 1'b1;
      end
    end
  end

  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  a_frame_gap: assert property (
    o_frame_start && seen_r |-> gap_r == per_h_r)
    else $error("frame period differs from programmed period");
  a_bypass_rate: assert property (
    o_frame_start && $past(i_bypass) && $past(prod) >= 19'h8
      |-> s.period_r == {$past(prod[16:0]), 2'b00})
    else $error("bypass frame period is not a quarter");

endmodule

// ==== tb/host_port_model.sv ====
// Host serial port model facing the device shift clock and frame sync.
// Assumes shift clock and frame sync are registered on the reference clock.
`timescale 1ns/1ps
module host_port_model (
  input wire logic i_ref_clk,
  input wire logic i_sclk,
  input wire logic i_frame_sync,
  input wire logic i_dout,
  input wire logic [15:0] i_tx_word,
  output logic o_din,
  output logic [15:0] o_rx_word,
  output int o_frames,
  output int o_bad
);
  logic sclk_q = 1'b0;
  logic dout_q = 1'b0;
  logic [15:0] tx = 16'h0000;
  logic [15:0] sh = 16'h0000;
  int nb = 16;
  int cyc = 0;

  initial begin
    o_din = 1'b0;
    o_rx_word = 16'h0000;
    o_frames = 0;
    o_bad = 0;
  end

  // ********
  // Frame tracking, shifting and edge checks
  // ********
  always @(posedge i_ref_clk) begin
    cyc = cyc + 1;
    if (i_dout !== dout_q && !(i_sclk && !sclk_q)) begin
      o_bad = o_bad + 1;
    end
    if (!i_frame_sync && i_sclk && !sclk_q) begin
      cyc = 0;
      nb = 0;
    end else if (nb < 16 && !i_sclk && sclk_q) begin
      sh = {sh[14:0], i_dout};
      nb = nb + 1;
      if (nb < 16) begin
        // Next bit right after the fall, stable through the next fall
        o_din <= tx[15 - nb];
      end else begin
        if (cyc != 31) begin
          o_bad = o_bad + 1;
        end
        o_rx_word <= sh;
        o_frames = o_frames + 1;
      end
    end else if (nb == 16 && i_sclk && !sclk_q) begin
      o_bad = o_bad + 1;
    end
    // Between frames the first bit of the next word waits on the pin
    if (nb == 16) begin
      tx = i_tx_word;
      o_din <= i_tx_word[15];
    end
    sclk_q = i_sclk;
    dout_q = i_dout;
  end
endmodule

// ==== tb/tb_codec_rate_ctrl.sv ====
// Self-checking bench of the rate and filter control block.
// Assumes the host port model on the serial pins and a 50 MHz clock.
`timescale 1ns/1ps
`include "codec_rate_params.svh"
module tb_codec_rate_ctrl;
  logic i_ref_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [15:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_mod_bit = 1'b0;
  logic [15:0] tx_word = 16'h0000;
  logic din;
  logic sclk;
  logic fsync;
  logic dout;
  logic adc_tick;
  logic dac_tick;
  logic fine;
  logic iir;
  logic byp;
  logic [15:0] rdata;
  logic [15:0] dac_word;
  logic [15:0] rx_word;
  logic [15:0] v;
  logic [15:0] word_a;
  logic [31:0] seed = 32'd92697;
  logic [16:0] cfg [0:4] = '{17'h03800, 17'h0007f, 17'h00780, 17'h01001, 17'h13803};
  int frames;
  int bad;
  int k;
  int na;
  int nd;
  int n_errors = 0;
  int tests_run = 0;

  always #10 i_ref_clk = ~i_ref_clk;

  codec_rate_ctrl u_codec_rate_ctrl (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .o_rdata(rdata),
    .i_din(din),
    .o_sclk(sclk),
    .o_frame_sync(fsync),
    .o_dout(dout),
    .i_mod_bit(i_mod_bit),
    .o_adc_tick(adc_tick),
    .o_dac_tick(dac_tick),
    .o_dac_word(dac_word),
    .o_fine_mode(fine),
    .o_iir_sel(iir),
    .o_bypass(byp)
  );

  host_port_model u_host_port_model (
    .i_ref_clk(i_ref_clk),
    .i_sclk(sclk),
    .i_frame_sync(fsync),
    .i_dout(dout),
    .i_tx_word(tx_word),
    .o_din(din),
    .o_rx_word(rx_word),
    .o_frames(frames),
    .o_bad(bad)
  );

  // ********
  // Model and helpers
  // ********
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  function automatic int exp_period(input logic [15:0] d, input logic b);
    int p;
    p = (int'(d[6:0]) + 1) * (int'(d[10:7]) + 1) * (int'(d[13:11]) + 1);
    return b ? 4 * p : 16 * p;
  endfunction

  task automatic check(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      $display("CHECK FAILED at %0t: %s", $time, msg);
      n_errors++;
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic tmo();
    $display("CHECK FAILED at %0t: wait ran out", $time);
    n_errors++;
    test_done();
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // Counts cycles and ticks up to the next frame start
  task automatic wait_fs();
    k = 0;
    na = 0;
    nd = 0;
    do begin
      @(posedge i_ref_clk);
      #1;
      k++;
      na += (adc_tick === 1'b1);
      nd += (dac_tick === 1'b1);
    end while (fsync !== 1'b0 && k < 5000);
    if (k >= 5000) begin
      tmo();
    end
  endtask

  task automatic settle();
    wait_fs();
    repeat (40) @(posedge i_ref_clk);
  endtask

  task automatic run_rate(input logic [15:0] div, input logic b);
    wr(`CR_A_CTRL2, {9'h000, b, 6'h00});
    wr(`CR_A_DIV, div);
    rd(`CR_A_STAT, v);
    check((v & 16'hfffd) === {13'h0000, b, 1'b0, div[13:11] != 3'h7}, "status");
    check(fine === (div[13:11] != 3'h7) && byp === b, "mode pins");
    wait_fs();
    wait_fs();
    wait_fs();
    check(k == exp_period(div, b), "frame period");
  endtask

  // ********
  // Main sequence
  // ********
  initial begin
    repeat (5) @(posedge i_ref_clk);
    check(fsync === 1'b1 && sclk === 1'b0, "serial pins in reset");
    i_resetn <= 1'b1;
    rd(`CR_A_DIV, v);
    check(v === `CR_DIV_RST && fine === 1'b0, "divider reset");
    rd(`CR_A_CTRL1, v);
    check(v === 16'h0000, "ctrl1 reset");
    rd(`CR_A_OVS, v);
    check(v === 16'h0000, "oversample reset");
    wr(4'hf, 16'hffff);
    rd(4'hf, v);
    check(v === 16'h0000, "unmapped read");
    for (int i = 0; i < 5; i++) run_rate(cfg[i][15:0], cfg[i][16]);
    check(na == 32, "adc ticks in bypass");
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      run_rate({2'b00, 3'(1 + seed[1:0]), 4'(seed[4]), 7'(1 + seed[9:8])}, 1'b0);
    end
    for (int i = 0; i < 4; i++) begin
      wr(`CR_A_OVS, 16'(i));
      rd(`CR_A_OVS, v);
      check(v === 16'(i), "oversample field");
      run_rate(16'h3803, 1'b0);
      check(na == 128 && nd == (i == 1 ? 256 : i == 2 ? 512 : 128), "ticks");
    end
    run_rate(`CR_DIV_RST, 1'b0);
    wr(`CR_A_CTRL1, 16'h0020);
    i_mod_bit <= 1'b1;
    repeat (4) settle();
    check(rx_word === 16'h7fff, "saturated word");
    rd(`CR_A_CTRL1, v);
    check(v === 16'h00a0 && iir === 1'b1, "overflow and filter bit");
    i_mod_bit <= 1'b0;
    repeat (3) settle();
    check(rx_word === 16'h8000, "negative full word");
    rd(`CR_A_CTRL1, v);
    check(v === 16'h0020, "overflow cleared by read");
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      tx_word <= seed[15:0];
      settle();
      settle();
      check(dac_word === seed[15:0], "dac word without delay");
    end
    wr(`CR_A_CTRL1, 16'h0000);
    seed = xs(seed);
    word_a = seed[15:0];
    tx_word <= word_a;
    repeat (22) settle();
    seed = xs(seed);
    tx_word <= seed[15:0];
    i_mod_bit <= 1'b1;
    repeat (12) settle();
    check(rx_word === 16'h8000 && dac_word === word_a && iir === 1'b0, "fir old");
    repeat (10) settle();
    check(rx_word === 16'h7fff && dac_word === seed[15:0], "fir new");
    check(bad == 0 && frames > 0, "serial framing");
    test_done();
  end
endmodule
